// ### design/mars_seq.sv
// Main converter round-robin sequencer with result registers and filters
// Behaviour
// - 24 slots of 8 us, 192 us cycle
// - Slots: die temp, reference, cells, shunt, inputs
// - Results 16-bit signed, high and low byte
// - Enabling resets all results to 0x8000
// - High-byte read freezes low byte until read
// - Cell count names highest active cell
// - Inactive cell slots keep their time
// - Inactive channels stay at 0x8000
// - Cells and shunt report raw or filtered
// - Shared 3-bit cutoff for all cells
// - Coefficient 1/2 down to 1/128
// - Filter primes with its first sample
// - Shunt filter has own enable, cutoff
// - Die temperature signed and clamped
// - One general input per cycle, eight total
// - Only converter-configured inputs are converted
// - Level shifters off outside active mode
// - Run modes stop, eight cycles, continuous
// - Settings latched on start command only; level shifters here follow the cell register directly
// - Data ready after eight cycles
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module mars_seq import mars_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_active,
  output logic conv_start,
  output logic [4:0] conv_slot,
  output logic [2:0] conv_input_sel,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic [15:0] level_shift_en,
  output logic bias_ref_enable
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic [4:0] ctrl_r;
  logic [6:0] conf_r;
  logic [3:0] cells_r;
  logic [23:0] incfg_r;
  logic bias_r;
  // Settings captured at the start command
  logic [1:0] mode_l;
  logic cell_en_l;
  logic shunt_en_l;
  logic [2:0] cell_sel_l;
  logic [2:0] shunt_sel_l;
  logic [4:0] ncells_l;
  logic [23:0] incfg_l;
  // Sequencer state
  mars_state_t state_r;
  logic [3:0] rr_cnt_r;
  logic [2:0] gpio_idx_r;
  logic conv_start_r;
  logic [4:0] conv_slot_r;
  logic [2:0] conv_sel_r;
  logic conv_pend_r;
  logic [4:0] conv_res_r;
  logic [15:0] lshift_r;
  // Results and filters
  logic [7:0] res_hi_r [NUM_RESULTS];
  logic [7:0] res_lo_r [NUM_RESULTS];
  logic [NUM_RESULTS-1:0] lock_r;
  logic [FW-1:0] filt_r [NUM_FILT];
  logic [NUM_FILT-1:0] primed_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
  endfunction

  // Field value 0 means six cells; anything past sixteen saturates
  function automatic logic [4:0] cell_count(input logic [3:0] f);
    cell_count = (f > 4'hA) ? MAX_CELLS : 5'(MIN_CELLS + {1'b0, f});
  endfunction

  function automatic logic input_converts(input logic [23:0] cfg, input logic [2:0] idx);
    logic [2:0] fn;
    fn = cfg[3*idx +: 3];
    input_converts = (fn == FN_ADC) | (fn == FN_ADC_OTUT);
  endfunction

  function automatic logic [15:0] die_clamp(input logic [15:0] d);
    if ($signed(d) > DIE_TEMP_MAX)
      die_clamp = DIE_TEMP_MAX;
    else if ($signed(d) < DIE_TEMP_MIN)
      die_clamp = DIE_TEMP_MIN;
    else
      die_clamp = d;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One wait state on every access; readdata is built in the waiting cycle
  wire acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_r;
  wire wr_go = avs_write & ack_r;
  wire rd_go = avs_read & ack_r;
  wire [8:0] res_ofs = 9'(avs_address - OFS_RESULT);
  wire res_hit = (avs_address >= OFS_RESULT) && (res_ofs < RESULT_SPAN);
  wire [4:0] res_idx = res_ofs[7:3];
  wire res_low = res_ofs[2];
  wire [31:0] ctrl_wd = merge({27'h0, ctrl_r}, avs_writedata, avs_byteenable);
  wire go_cmd = wr_go && (avs_address == OFS_CTRL_ONE) && ctrl_wd[CTRL_GO_POS];
  wire [1:0] go_mode = ctrl_wd[CTRL_MODE_POS +: 2];
  wire go_run = go_cmd && ((go_mode == MODE_BURST) || (go_mode == MODE_CONT));
  wire go_stop = go_cmd && !go_run;

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (avs_address == OFS_CTRL_ONE)
      rd_val = {27'h0, 1'b0, ctrl_r[3:0]};
    else if (avs_address == OFS_CONF_ONE)
      rd_val = {25'h0, conf_r};
    else if (avs_address == OFS_CELLS)
      rd_val = {28'h0, cells_r};
    else if (avs_address == OFS_INPUT_CFG)
      rd_val = {8'h0, incfg_r};
    else if (avs_address == OFS_DEV_CTRL_TWO)
      rd_val = {31'h0, bias_r};
    else if (avs_address == OFS_STATUS)
      rd_val = {30'h0, rr_cnt_r >= RR_BURST, state_r == MARS_RUN};
    else if (res_hit && avs_address[1:0] == 2'h0)
      rd_val = {24'h0, res_low ? res_lo_r[res_idx] : res_hi_r[res_idx]};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (clk_en) begin
      ack_r <= acc & ~ack_r;
      if (avs_read & ~ack_r)
        rdata_r <= rd_val;
    end
  end
  assign avs_readdata = rdata_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= 5'h00;
      conf_r <= 7'h00;
      cells_r <= CELLS_RESET;
      incfg_r <= 24'h0;
      bias_r <= 1'b0;
    end else if (clk_en && wr_go) begin
      if (avs_address == OFS_CTRL_ONE)
        ctrl_r <= {1'b0, ctrl_wd[3:0]};
      else if (avs_address == OFS_CONF_ONE)
        conf_r <= 7'(merge({25'h0, conf_r}, avs_writedata, avs_byteenable) & 32'h77);
      else if (avs_address == OFS_CELLS)
        cells_r <= 4'(merge({28'h0, cells_r}, avs_writedata, avs_byteenable));
      else if (avs_address == OFS_INPUT_CFG)
        incfg_r <= 24'(merge({8'h0, incfg_r}, avs_writedata, avs_byteenable));
      else if (avs_address == OFS_DEV_CTRL_TWO)
        bias_r <= 1'(merge({31'h0, bias_r}, avs_writedata, avs_byteenable));
    end
  end
  assign bias_ref_enable = bias_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [4:0] slot;
  logic slot_start;
  logic cycle_end;
  // slot timing, frozen outside active mode
  mars_slot_timer u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .run((state_r == MARS_RUN) & power_active),
    .restart(go_cmd),
    .slot(slot),
    .slot_start(slot_start),
    .cycle_end(cycle_end)
  );

  // slot set and order; cells above the count idle in place
  wire [4:0] cell_no = 5'(slot - SLOT_CELL0 + 5'h01);
  wire is_cell = (slot >= SLOT_CELL0) && (slot < SLOT_SHUNT);
  // shared input slot, one input per cycle
  wire slot_conv = (slot == SLOT_DIE) || (slot == SLOT_THERMISTOR_BIAS_REFERENCE) || (slot == SLOT_SHUNT)
                   || (is_cell && cell_no <= ncells_l)
                   || (slot == SLOT_GPIO && input_converts(incfg_l, gpio_idx_r));
  wire [4:0] slot_res = (slot == SLOT_GPIO) ? 5'(SLOT_GPIO + {2'h0, gpio_idx_r}) : slot;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= MARS_IDLE;
      rr_cnt_r <= 4'h0;
      gpio_idx_r <= 3'h0;
      mode_l <= MODE_STOP;
      cell_en_l <= 1'b0;
      shunt_en_l <= 1'b0;
      cell_sel_l <= 3'h0;
      shunt_sel_l <= 3'h0;
      ncells_l <= MAX_CELLS;
      incfg_l <= 24'h0;
    end else if (clk_en) begin
      // settings captured only by the start command
      if (go_cmd) begin
        mode_l <= go_mode;
        cell_en_l <= ctrl_wd[CTRL_CELL_EN_POS];
        shunt_en_l <= ctrl_wd[CTRL_SHUNT_EN_POS];
        cell_sel_l <= conf_r[CONF_CELL_SEL_POS +: 3];
        shunt_sel_l <= conf_r[CONF_SHUNT_SEL_POS +: 3];
        ncells_l <= cell_count(cells_r);
        incfg_l <= incfg_r;
        rr_cnt_r <= 4'h0;
        gpio_idx_r <= 3'h0;
        // stop code or reserved code halts the converter
        state_r <= go_run ? MARS_RUN : MARS_IDLE;
      end else if (cycle_end) begin
        gpio_idx_r <= 3'(gpio_idx_r + 3'h1);
        if (rr_cnt_r < RR_BURST)
          rr_cnt_r <= 4'(rr_cnt_r + 4'h1);
        // burst mode stops after its eighth cycle
        if (mode_l == MODE_BURST && rr_cnt_r == 4'(RR_BURST - 4'h1))
          state_r <= MARS_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_start_r <= 1'b0;
      conv_slot_r <= 5'h00;
      conv_sel_r <= 3'h0;
      conv_pend_r <= 1'b0;
      conv_res_r <= 5'h00;
      lshift_r <= 16'h0;
    end else if (clk_en) begin
      conv_start_r <= slot_start & slot_conv;
      if (slot_start & slot_conv) begin
        conv_slot_r <= slot;
        conv_sel_r <= gpio_idx_r;
        conv_res_r <= slot_res;
      end
      // A late answer is dropped once the next slot begins
      if (go_cmd || slot_start)
        conv_pend_r <= ~go_cmd & slot_conv;
      else if (conv_done)
        conv_pend_r <= 1'b0;
      // level shifters only in active mode, for active cells
      lshift_r <= power_active ? 16'((17'h1 << cell_count(cells_r)) - 17'h1) : 16'h0;
    end
  end
  assign conv_start = conv_start_r;
  assign conv_slot = conv_slot_r;
  assign conv_input_sel = conv_sel_r;
  assign level_shift_en = lshift_r;

  // ----------------------------------------
  // Filtering and result registers
  // ----------------------------------------
  wire is_filt_ch = (conv_res_r >= SLOT_CELL0) && (conv_res_r <= SLOT_SHUNT);
  wire [4:0] fidx = is_filt_ch ? 5'(conv_res_r - SLOT_CELL0) : 5'h00;
  wire is_shunt = (conv_res_r == SLOT_SHUNT);
  // shunt filter settings independent of the cells
  wire filt_on = is_filt_ch & (is_shunt ? shunt_en_l : cell_en_l);
  // one shared cutoff for all cells
  wire [2:0] fshift = coef_shift(is_shunt ? shunt_sel_l : cell_sel_l);
  wire [FW-1:0] filt_next;
  wire [15:0] filt_out;
  // one filter step per conversion, i.e. per cycle
  mars_lpf u_lpf (
    .state(filt_r[fidx]),
    .sample(conv_data),
    .shift(fshift),
    .init(~primed_r[fidx]),
    .next(filt_next),
    .out(filt_out)
  );

  wire res_wr = conv_done & conv_pend_r & ~go_cmd;
  wire [15:0] res_val = (conv_res_r == SLOT_DIE) ? die_clamp(conv_data) : (filt_on ? filt_out : conv_data);
  wire lock_set = rd_go & res_hit & ~res_low;
  wire lock_clr = rd_go & res_hit & res_low;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      primed_r <= '0;
      for (int i = 0; i < NUM_FILT; i++)
        filt_r[i] <= '0;
    end else if (clk_en) begin
      // every start re-primes so the first sample seeds the state
      if (go_cmd)
        primed_r <= '0;
      else if (res_wr && filt_on) begin
        primed_r[fidx] <= 1'b1;
        filt_r[fidx] <= filt_next;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_r <= '0;
      for (int i = 0; i < NUM_RESULTS; i++) begin
        res_hi_r[i] <= RESULT_RESET[15:8];
        res_lo_r[i] <= RESULT_RESET[7:0];
      end
    end else if (clk_en) begin
      // all results back to the default on enabling
      if (go_run) begin
        lock_r <= '0;
        for (int i = 0; i < NUM_RESULTS; i++) begin
          res_hi_r[i] <= RESULT_RESET[15:8];
          res_lo_r[i] <= RESULT_RESET[7:0];
        end
      end else begin
        // high-byte read holds the low byte until it is read
        if (lock_set)
          lock_r[res_idx] <= 1'b1;
        else if (lock_clr)
          lock_r[res_idx] <= 1'b0;
        if (res_wr) begin
          res_hi_r[conv_res_r] <= res_val[15:8];
          if (!lock_r[conv_res_r] && !(lock_set && res_idx == conv_res_r))
            res_lo_r[conv_res_r] <= res_val[7:0];
        end
      end
    end
  end
endmodule

// ### design/mars_pkg.sv
// Shared constants for the main converter round-robin sequencer
package mars_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SLOT_TIME_NS = 8000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SLOT_LAST = 9'(SLOT_CYCLES - 1);
  localparam logic [4:0] NUM_SLOTS = 5'h18;
  localparam logic [4:0] SLOT_LAST_IDX = 5'h17;
  localparam logic [3:0] RR_BURST = 4'h8;
  // ----------------------------------------
  // Slot map and result index map
  // ----------------------------------------
  localparam logic [4:0] SLOT_DIE = 5'h00;
  localparam logic [4:0] SLOT_THERMISTOR_BIAS_REFERENCE = 5'h01;
  localparam logic [4:0] SLOT_CELL0 = 5'h02;
  localparam logic [4:0] SLOT_SHUNT = 5'h12;
  localparam logic [4:0] SLOT_GPIO = 5'h13;
  localparam int NUM_RESULTS = 27;
  localparam int NUM_FILT = 17;
  localparam logic [4:0] FILT_SHUNT = 5'h10;
  localparam logic [15:0] RESULT_RESET = 16'h8000;
  // Die temperature clamp codes (+200 C / -100 C at the converter's scale)
  localparam logic signed [15:0] DIE_TEMP_MAX = 16'sh0C80;
  localparam logic signed [15:0] DIE_TEMP_MIN = 16'shF9C0;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [8:0] OFS_CTRL_ONE = 9'h000;
  localparam logic [8:0] OFS_CONF_ONE = 9'h004;
  localparam logic [8:0] OFS_CELLS = 9'h008;
  localparam logic [8:0] OFS_INPUT_CFG = 9'h00C;
  localparam logic [8:0] OFS_DEV_CTRL_TWO = 9'h010;
  localparam logic [8:0] OFS_STATUS = 9'h014;
  localparam logic [8:0] OFS_RESULT = 9'h100;
  localparam logic [8:0] RESULT_SPAN = 9'h0D8;
  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_CELL_EN_POS = 2;
  localparam int CTRL_SHUNT_EN_POS = 3;
  localparam int CTRL_GO_POS = 4;
  localparam int CONF_CELL_SEL_POS = 0;
  localparam int CONF_SHUNT_SEL_POS = 4;
  localparam int STAT_RUN_POS = 0;
  localparam int STAT_DRDY_POS = 1;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [2:0] FN_ADC = 3'h2;
  localparam logic [2:0] FN_ADC_OTUT = 3'h3;
  localparam logic [4:0] MIN_CELLS = 5'h06;
  localparam logic [4:0] MAX_CELLS = 5'h10;
  localparam logic [3:0] CELLS_RESET = 4'hA;
  localparam int FRAC = 7;
  localparam int FW = 16 + FRAC;

  typedef enum logic {MARS_IDLE, MARS_RUN} mars_state_t;

  // Cutoff code 0 is the slowest (coefficient 1/128), 6 the fastest (1/2)
  function automatic logic [2:0] coef_shift(input logic [2:0] sel);
    coef_shift = (sel > 3'h6) ? 3'h1 : 3'(3'h7 - sel);
  endfunction
endpackage

// ### design/mars_slot_timer.sv
// Slot and cycle timing of the round robin
`timescale 1ns/10ps
module mars_slot_timer import mars_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic restart,
  output logic [4:0] slot,
  output logic slot_start,
  output logic cycle_end
);
  logic [8:0] tick_r;
  logic [4:0] slot_r;
  wire slot_done = (tick_r == SLOT_LAST);

  assign slot = slot_r;
  assign slot_start = run & ~restart & (tick_r == 9'h000);
  assign cycle_end = run & ~restart & slot_done & (slot_r == SLOT_LAST_IDX);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick_r <= 9'h000;
      slot_r <= 5'h00;
    end else if (clk_en) begin
      if (restart) begin
        tick_r <= 9'h000;
        slot_r <= 5'h00;
      end else if (run) begin
        tick_r <= slot_done ? 9'h000 : 9'(tick_r + 9'h001);
        if (slot_done)
          slot_r <= (slot_r == SLOT_LAST_IDX) ? 5'h00 : 5'(slot_r + 5'h01);
      end
    end
  end
endmodule

// ### design/mars_lpf.sv
// Single-pole low-pass filter step, shared by all filtered channels
`timescale 1ns/10ps
module mars_lpf import mars_pkg::*; (
  input wire logic [FW-1:0] state,
  input wire logic [15:0] sample,
  input wire logic [2:0] shift,
  input wire logic init,
  output logic [FW-1:0] next,
  output logic [15:0] out
);
  wire signed [FW:0] s_ext = $signed({sample[15], sample, {FRAC{1'b0}}});
  wire signed [FW:0] st_ext = $signed({state[FW-1], state});
  wire signed [FW:0] diff = s_ext - st_ext;
  // Fractional bits kept in the state so tiny coefficients still move it
  wire signed [FW:0] step = diff >>> shift;
  wire signed [FW:0] sum = st_ext + step;

  assign next = init ? s_ext[FW-1:0] : sum[FW-1:0];
  assign out = next[FW-1:FRAC];
endmodule

// ### tb/mars_seq_monitor.sv
// Port-level assertions for the round-robin sequencer
`timescale 1ns/10ps
module mars_seq_monitor import mars_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic power_active,
  input wire logic conv_start,
  input wire logic [4:0] conv_slot,
  input wire logic [2:0] conv_input_sel,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] level_shift_en,
  input wire logic bias_ref_enable
);
  // ----------------------------------------
  // Cycle tracking
  // ----------------------------------------
  logic [13:0] gap_r;
  logic seen_r;
  logic [4:0] last_slot_r;
  wire go_wr = avs_write && !avs_waitrequest && avs_address == OFS_CTRL_ONE && avs_writedata[CTRL_GO_POS];
  wire die_start = conv_start && conv_slot == SLOT_DIE;
  // A go restarts the timer, so the span up to the first die slot after it is not measured
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 14'h0000;
      seen_r <= 1'b0;
      last_slot_r <= 5'h00;
    end else if (clk_en) begin
      gap_r <= die_start ? 14'h0000 : gap_r + 14'h0001;
      seen_r <= go_wr ? 1'b0 : (seen_r | die_start);
      if (conv_start) begin
        last_slot_r <= conv_slot;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_bus_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  a_start_single: assert property (conv_start |=> !conv_start [*8])
    else $error("conversion start not a lone pulse");
  a_slot_spacing: assert property (conv_start && conv_slot == SLOT_THERMISTOR_BIAS_REFERENCE && seen_r |-> gap_r == 14'h018F)
    else $error("reference slot not 400 cycles after die slot");
  a_cycle_period: assert property (die_start && seen_r |-> gap_r == 14'h257F)
    else $error("round-robin cycle not 9600 cycles");
  a_slot_order: assert property (conv_start && conv_slot != SLOT_DIE |-> conv_slot > last_slot_r)
    else $error("slot visited out of order");
  a_spare_idle: assert property (conv_start |-> conv_slot <= SLOT_GPIO)
    else $error("spare slot converted");
  a_shift_off: assert property (!power_active |=> level_shift_en == 16'h0000)
    else $error("level shifters on outside active mode");
endmodule

bind mars_seq mars_seq_monitor mars_seq_monitor_inst (
  .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .power_active(power_active), .conv_start(conv_start), .conv_slot(conv_slot),
  .conv_input_sel(conv_input_sel), .conv_done(conv_done), .conv_data(conv_data),
  .level_shift_en(level_shift_en), .bias_ref_enable(bias_ref_enable)
);

// ### tb/mars_conv_model.sv
// Behavioural converter answering start requests with slot-coded samples
`timescale 1ns/10ps
module mars_conv_model import mars_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic conv_start,
  input wire logic [4:0] conv_slot,
  input wire logic [2:0] conv_input_sel,
  input wire logic signed [15:0] base,
  input wire logic slow,
  output logic conv_done,
  output logic [15:0] conv_data
);
  logic pend_r;
  logic [8:0] dly_r;
  logic [15:0] last_r;
  // Slow answers still land before the next slot opens
  // The input number only marks samples of the shared general-input slot
  wire [15:0] val = (conv_slot == SLOT_DIE) ? 16'(base * 16'sh0008)
                    : base + {conv_slot, 4'h0} + ((conv_slot == SLOT_GPIO) ? conv_input_sel : 3'h0);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      dly_r <= 9'h000;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
      last_r <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~last_r;
      if (conv_start) begin
        pend_r <= 1'b1;
        dly_r <= slow ? 9'h15E : 9'h002;
      end else if (pend_r && dly_r == 9'h000) begin
        pend_r <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= val;
        last_r <= val;
      end else if (pend_r) begin
        dly_r <= dly_r - 9'h001;
      end
    end
  end
endmodule

// ### tb/mars_seq_tb.sv
// Self-checking bench: host bus tasks, result model, converter partner
`timescale 1ns/10ps
module mars_seq_tb import mars_pkg::*;;
  logic core_clk = 0, resetn = 0, clk_en = 1, avs_read = 0, avs_write = 0, power_active = 1, slow = 0;
  logic [8:0] avs_address = 9'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, conv_start, conv_done, bias_ref_enable;
  logic [4:0] conv_slot;
  logic [2:0] conv_input_sel;
  logic [15:0] conv_data, level_shift_en;
  logic signed [15:0] base = 16'sh0000;
  int seed = 59572, mismatches = 0, comparisons = 0, cyc = 0;
  int go_cyc, cells, cfg, sc, ss, x, h;
  int st[27], ev[27];
  mars_seq mars_seq_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_active(power_active),
    .conv_start(conv_start), .conv_slot(conv_slot), .conv_input_sel(conv_input_sel), .conv_done(conv_done),
    .conv_data(conv_data), .level_shift_en(level_shift_en), .bias_ref_enable(bias_ref_enable));
  mars_conv_model mars_conv_model_inst (.core_clk(core_clk), .resetn(resetn), .conv_start(conv_start),
    .conv_slot(conv_slot), .conv_input_sel(conv_input_sel), .base(base), .slow(slow), .conv_done(conv_done),
    .conv_data(conv_data));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) mismatches++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic res(input int k, input int e);
    bus(0, 9'(OFS_RESULT + 8 * k), 0);
    chk(q, (e >> 8) & 255);
    bus(0, 9'(OFS_RESULT + 8 * k + 4), 0);
    chk(q, e & 255);
  endtask
  task automatic wait_to(input int n);
    while (cyc < go_cyc + n) @(posedge core_clk);
  endtask
  // single-pole step, primed on the first sample
  function automatic int filt(int k, int v, int s, int c);
    if (c == 0) st[k] = v * 128;
    else st[k] = st[k] + ((v * 128 - st[k]) >>> s);
    return (st[k] >>> 7) & 32'hFFFF;
  endfunction
  task automatic step(input int c);
    for (int s = 0; s < 19; s++) begin
      x = (s == 0) ? base * 8 : base + s * 16;
      if (s == 0) ev[0] = (x > 3200 ? 3200 : (x < -1600 ? -1600 : x)) & 32'hFFFF;
      else if (s == 1) ev[1] = x & 32'hFFFF;
      else if (s == 18) ev[18] = filt(18, x, ss > 6 ? 1 : 7 - ss, c);
      else if (s - 1 <= cells) ev[s] = filt(s, x, sc > 6 ? 1 : 7 - sc, c);
    end
    x = base + 19 * 16 + c;
    if (((cfg >> (3 * c)) & 7) inside {2, 3}) ev[19 + c] = x & 32'hFFFF;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    res(0, 16'h8000);
    bus(0, 9'h1F0, 0);
    chk(q, 0);
    // bias reference on before any thermistor use
    bus(1, OFS_DEV_CTRL_TWO, 1);
    x = $random(seed) & 15;
    cells = (x >= 10) ? 16 : 6 + x;
    cfg = $random(seed) & 32'hFFFFFF;
    sc = $random(seed) & 7;
    ss = $random(seed) & 7;
    bus(1, OFS_CELLS, x);
    bus(1, OFS_INPUT_CFG, cfg);
    bus(1, OFS_CONF_ONE, sc | (ss << 4));
    chk(bias_ref_enable, 1);
    chk(level_shift_en, 32'((1 << cells) - 1));
    base <= 16'($random(seed) % 4096);
    bus(1, OFS_CTRL_ONE, 32'h1E);
    go_cyc = cyc;
    for (int k = 0; k < 27; k++) ev[k] = 32'h8000;
    bus(1, OFS_CONF_ONE, ~(sc | (ss << 4)));
    $display("setup done, %0d cells", cells);
    for (int c = 0; c < 8; c++) begin
      wait_to(c * 9600 + 8100);
      step(c);
      if (c == 3) begin
        bus(0, 9'(OFS_RESULT + 16), 0);
        chk(q, (ev[2] >> 8) & 255);
        h = ev[2];
      end
      if (c == 4) begin
        bus(0, 9'(OFS_RESULT + 20), 0);
        chk(q, h & 255);
      end
      if (c == 7) begin
        bus(0, OFS_STATUS, 0);
        chk(q, 1);
        for (int k = 0; k < 27; k++) res(k, ev[k]);
      end
      base <= 16'($random(seed) % 4096);
      slow <= $random(seed) & 1;
    end
    $display("round robin results done");
    wait_to(8 * 9600 + 500);
    bus(0, OFS_STATUS, 0);
    chk(q, 3);
    bus(1, OFS_CTRL_ONE, 32'h10);
    bus(0, OFS_STATUS, 0);
    chk(q, 0);
    bus(1, OFS_CTRL_ONE, 32'h11);
    bus(0, OFS_STATUS, 0);
    chk(q, 1);
    res(2, 16'h8000);
    repeat (600) @(posedge core_clk);
    bus(1, OFS_CTRL_ONE, 32'h10);
    $display("run modes done");
    power_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(level_shift_en, 0);
    power_active <= 1'b1;
    $display("power mode done");
    end_of_test();
  end
  // Whole run is about 80000 cycles
  initial begin
    #1800000;
    mismatches++;
    end_of_test();
  end
endmodule
